//--- hw/cws_pkg.sv
// cws_pkg: constants and types for the shutdown / rising dead-band block
// assumes one 125 MHz clock and an ahb-lite slave with single word transfers
package cws_pkg;
  localparam logic [11:0] OFF_SHDN_CTRL = 12'h000;
  localparam logic [11:0] OFF_DBR       = 12'h004;
  localparam logic [11:0] OFF_LEVELS    = 12'h008;
  localparam logic [11:0] OFF_INT_STAT  = 12'h00c;
  localparam logic [11:0] OFF_INT_EN    = 12'h010;
  localparam logic [11:0] OFF_INT_CLR   = 12'h014;
  localparam logic [11:0] OFF_WAVE_CTRL = 12'h018;

  localparam int unsigned BIT_EVENT  = 7;
  localparam int unsigned BIT_ARS    = 6;
  localparam int unsigned BIT_LCE    = 1;
  localparam int unsigned BIT_FLTE   = 0;
  localparam logic [7:0]  CTRL_MASK  = 8'hc3;
  localparam logic [7:0]  DBR_MASK   = 8'h3f;
  localparam logic [7:0]  CTRL_RESET = 8'h00;

  localparam logic [1:0] LVL_INACTIVE = 2'h0;
  localparam logic [1:0] LVL_TRISTATE = 2'h1;
  localparam logic [1:0] LVL_LOW      = 2'h2;
  localparam logic [1:0] LVL_HIGH     = 2'h3;

  localparam int unsigned INT_SHDN    = 0;
  localparam int unsigned INT_RESTART = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic       event_flag;
    logic       auto_restart_enable;
    logic       logic_cell_shutdown_enable;
    logic       fault_pin_shutdown_enable;
  } cws_ctrl_t;

  typedef struct packed {
    logic       oe;     // active low output enable
    logic       level;
  } cws_pin_t;

  typedef struct packed {
    cws_ctrl_t  ctrl;
    logic [5:0] rising_deadband_field;
    logic [1:0] out_a_shutdown_level;
    logic [1:0] out_b_shutdown_level;
    logic       out_a_enable;
    logic       out_b_enable;
    logic       out_a_polarity;
    logic       out_b_polarity;
    logic [1:0] int_stat;
    logic [1:0] int_en;
    logic [5:0] db_cnt;
    logic       a_drive;
    logic       b_drive;
    logic       src_prev;
    logic       ph_sel;
    logic       ph_write;
    logic [11:0] ph_addr;
    logic [31:0] rdata;
    logic [1:0] flt_sync;
  } cws_state_t;
endpackage

//--- hw/cws_shutdown.sv
// cws_shutdown: auto-shutdown and rising dead-band for a complementary waveform pair
// assumes waveform input and logic cell output on clk; fault pin asynchronous
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module cws_shutdown (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        db_tick,
  input  wire logic        wave_in,
  input  wire logic        logic_cell_output,
  input  wire logic        fault_input_pin,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output cws_pkg::cws_pin_t wave_out_a,
  output cws_pkg::cws_pin_t wave_out_b,
  output logic             irq
);
  cws_pkg::cws_state_t s_q;
  cws_pkg::cws_state_t s_d;
  logic                src_act;
  logic                a_raw;
  logic                b_raw;
  logic                wr_chk;
  logic                rd_chk;

  function automatic cws_pkg::cws_pin_t pin_out(input logic shdn, input logic [1:0] lvl,
                                                input logic en, input logic pol,
                                                input logic drv);
    cws_pkg::cws_pin_t p;
    p.oe    = 1'b0;
    p.level = drv ^ pol;
    if (shdn) begin
      case (lvl)
        cws_pkg::LVL_TRISTATE: p.oe = 1'b1;
        cws_pkg::LVL_LOW:      p.level = 1'b0;
        cws_pkg::LVL_HIGH:     p.level = 1'b1;
        default:               p.level = pol;
      endcase
    end else if (!en) begin
      p.oe = 1'b1;
    end
    return p;
  endfunction

  // a transfer is taken for NONSEQ or SEQ; IDLE and BUSY are ignored
  function automatic logic is_xfer(input logic [1:0] trans);
    return (trans == cws_pkg::HTRANS_NONSEQ) || (trans == cws_pkg::HTRANS_SEQ);
  endfunction

  // control byte as software sees it; bits 5 to 2 are not implemented
  function automatic logic [7:0] ctrl_byte(input cws_pkg::cws_ctrl_t c);
    logic [7:0] b;
    b                     = 8'h00;
    b[cws_pkg::BIT_EVENT] = c.event_flag;
    b[cws_pkg::BIT_ARS]   = c.auto_restart_enable;
    b[cws_pkg::BIT_LCE]   = c.logic_cell_shutdown_enable;
    b[cws_pkg::BIT_FLTE]  = c.fault_pin_shutdown_enable;
    return b & cws_pkg::CTRL_MASK;
  endfunction

  // control bits from a byte; used by the write path and by reset
  function automatic cws_pkg::cws_ctrl_t ctrl_from(input logic [7:0] b);
    cws_pkg::cws_ctrl_t c;
    c.event_flag                 = b[cws_pkg::BIT_EVENT];
    c.auto_restart_enable        = b[cws_pkg::BIT_ARS];
    c.logic_cell_shutdown_enable = b[cws_pkg::BIT_LCE];
    c.fault_pin_shutdown_enable  = b[cws_pkg::BIT_FLTE];
    return c;
  endfunction

  // fault pin is active low; stage 2 of the synchroniser is the only reader
  assign src_act = (s_q.ctrl.logic_cell_shutdown_enable & logic_cell_output) |
                   (s_q.ctrl.fault_pin_shutdown_enable & ~s_q.flt_sync[1]);

  always_comb begin
    logic       wr;
    logic       rd;
    logic [7:0] w8;
    wr   = 1'b0;
    rd   = 1'b0;
    w8   = 8'h00;
    s_d  = s_q;
    s_d.flt_sync = {s_q.flt_sync[0], fault_input_pin};
    s_d.src_prev = src_act;
    s_d.ph_sel   = hsel & hready & is_xfer(htrans);
    if (hready) begin
      s_d.ph_write = hwrite;
      s_d.ph_addr  = haddr[11:0];
    end
    wr = wr_chk;
    rd = rd_chk;
    w8 = hwdata[7:0];
    if (wr) begin
      case (s_q.ph_addr)
        cws_pkg::OFF_SHDN_CTRL: s_d.ctrl = ctrl_from(w8);
        cws_pkg::OFF_DBR:    s_d.rising_deadband_field = w8[5:0];
        cws_pkg::OFF_LEVELS: begin
          s_d.out_a_shutdown_level = w8[1:0];
          s_d.out_b_shutdown_level = w8[3:2];
        end
        cws_pkg::OFF_INT_EN:  s_d.int_en = w8[1:0];
        cws_pkg::OFF_INT_CLR: s_d.int_stat = s_q.int_stat & ~w8[1:0];
        cws_pkg::OFF_WAVE_CTRL: begin
          s_d.out_a_enable   = w8[0];
          s_d.out_b_enable   = w8[1];
          s_d.out_a_polarity = w8[2];
          s_d.out_b_polarity = w8[3];
        end
        default: ;
      endcase
    end
    // hardware set wins over a software write or clear in the same cycle
    if (src_act) begin
      s_d.ctrl.event_flag = 1'b1;
      if (!s_q.ctrl.event_flag) s_d.int_stat[cws_pkg::INT_SHDN] = 1'b1;
    end else if (s_q.ctrl.event_flag && s_q.ctrl.auto_restart_enable && !wr) begin
      s_d.ctrl.event_flag = 1'b0;
      s_d.int_stat[cws_pkg::INT_RESTART] = 1'b1;
    end
    // rising dead band: the b side falls at once, a rises after n ticks
    s_d.b_drive = ~wave_in;
    if (!wave_in) begin
      s_d.a_drive = 1'b0;
      s_d.db_cnt  = s_q.rising_deadband_field;
    end else if (s_q.rising_deadband_field == 6'h00) begin
      s_d.a_drive = 1'b1;
    end else if (!s_q.a_drive && db_tick) begin
      if (s_q.db_cnt <= 6'h01) s_d.a_drive = 1'b1;
      else s_d.db_cnt = s_q.db_cnt - 6'h01;
    end
    s_d.rdata = 32'h0000_0000;
    if (rd) begin
      case (haddr[11:0])
        cws_pkg::OFF_SHDN_CTRL: s_d.rdata[7:0] = ctrl_byte(s_d.ctrl);
        cws_pkg::OFF_DBR:    s_d.rdata[7:0] = {2'h0, s_q.rising_deadband_field};
        cws_pkg::OFF_LEVELS: s_d.rdata[7:0] = {4'h0, s_q.out_b_shutdown_level,
                                               s_q.out_a_shutdown_level};
        cws_pkg::OFF_INT_STAT: s_d.rdata[7:0] = {6'h00, s_q.int_stat};
        cws_pkg::OFF_INT_EN:   s_d.rdata[7:0] = {6'h00, s_q.int_en};
        cws_pkg::OFF_WAVE_CTRL: s_d.rdata[7:0] = {4'h0, s_q.out_b_polarity,
          s_q.out_a_polarity, s_q.out_b_enable, s_q.out_a_enable};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (reset) begin
      s_d      = s_q;
      s_d.ctrl = ctrl_from(cws_pkg::CTRL_RESET);
      s_d.out_a_shutdown_level = cws_pkg::LVL_INACTIVE;
      s_d.out_b_shutdown_level = cws_pkg::LVL_INACTIVE;
      s_d.out_a_enable   = 1'b0;
      s_d.out_b_enable   = 1'b0;
      s_d.out_a_polarity = 1'b0;
      s_d.out_b_polarity = 1'b0;
      s_d.int_stat = 2'h0;
      s_d.int_en   = 2'h0;
      s_d.db_cnt   = 6'h00;
      s_d.a_drive  = 1'b0;
      s_d.b_drive  = 1'b0;
      s_d.src_prev = 1'b0;
      s_d.ph_sel   = 1'b0;
      s_d.ph_write = 1'b0;
      s_d.ph_addr  = 12'h000;
      s_d.rdata    = 32'h0000_0000;
      s_d.flt_sync = 2'h3;
      // dead band field keeps its value across reset
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign a_raw = s_q.a_drive;
  assign b_raw = s_q.b_drive;
  assign wave_out_a = pin_out(s_q.ctrl.event_flag, s_q.out_a_shutdown_level,
                              s_q.out_a_enable, s_q.out_a_polarity, a_raw);
  assign wave_out_b = pin_out(s_q.ctrl.event_flag, s_q.out_b_shutdown_level,
                              s_q.out_b_enable, s_q.out_b_polarity, b_raw);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign irq       = |(s_q.int_stat & s_q.int_en);
  assign wr_chk    = s_q.ph_sel & s_q.ph_write;
  assign rd_chk    = hsel & hready & ~hwrite & is_xfer(htrans);

  a_src_sets_flag: assert property (@(posedge clk) disable iff (reset)
    src_act |=> s_q.ctrl.event_flag)
    else $error("shutdown source did not set the event flag");
  a_flag_clear_run: assert property (@(posedge clk) disable iff (reset)
    (!s_q.ctrl.event_flag && s_q.out_a_enable) |-> !wave_out_a.oe)
    else $error("enabled output not driven without shutdown");
  a_reset_clears: assert property (@(posedge clk)
    reset |=> (ctrl_byte(s_q.ctrl) == cws_pkg::CTRL_RESET))
    else $error("control not cleared by reset");
  a_auto_restart: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.ctrl.auto_restart_enable && !src_act && !wr_chk)
    |=> !s_q.ctrl.event_flag)
    else $error("auto restart did not clear the flag");
  a_lc_ignored: assert property (@(posedge clk) disable iff (reset)
    (!s_q.ctrl.logic_cell_shutdown_enable && !s_q.ctrl.fault_pin_shutdown_enable)
    |-> !src_act)
    else $error("disabled source caused shutdown");
  a_fault_low: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.fault_pin_shutdown_enable && !s_q.flt_sync[1]) |=> s_q.ctrl.event_flag)
    else $error("low fault pin did not shut down");
  a_zero_db: assert property (@(posedge clk) disable iff (reset)
    (s_q.rising_deadband_field == 6'h00 && wave_in) |=> s_q.a_drive)
    else $error("zero dead band delayed the rising edge");
  a_db_hold: assert property (@(posedge clk) disable iff (reset)
    ($rose(wave_in) && s_q.rising_deadband_field > 6'h01) |=> !s_q.a_drive)
    else $error("rising edge passed without dead band");
  a_level_high: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_b_shutdown_level == cws_pkg::LVL_HIGH)
    |-> (wave_out_b.level && !wave_out_b.oe))
    else $error("forced high level not driven");
  a_stat_on_entry: assert property (@(posedge clk) disable iff (reset)
    (src_act && !s_q.ctrl.event_flag) |=> s_q.int_stat[cws_pkg::INT_SHDN])
    else $error("shutdown entry not recorded in status");
  a_override_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_a_shutdown_level != cws_pkg::LVL_TRISTATE)
    |-> !wave_out_a.oe)
    else $error("shutdown did not override enable a");
  a_override_b: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_b_shutdown_level != cws_pkg::LVL_TRISTATE)
    |-> !wave_out_b.oe)
    else $error("shutdown did not override enable b");
  a_disabled_a: assert property (@(posedge clk) disable iff (reset)
    (!s_q.ctrl.event_flag && !s_q.out_a_enable) |-> wave_out_a.oe)
    else $error("disabled output a driven");
  a_disabled_b: assert property (@(posedge clk) disable iff (reset)
    (!s_q.ctrl.event_flag && !s_q.out_b_enable) |-> wave_out_b.oe)
    else $error("disabled output b driven");
  a_enabled_b: assert property (@(posedge clk) disable iff (reset)
    (!s_q.ctrl.event_flag && s_q.out_b_enable) |-> !wave_out_b.oe)
    else $error("enabled output b not driven");
  a_ctrl_write: assert property (@(posedge clk) disable iff (reset)
    (wr_chk && s_q.ph_addr == cws_pkg::OFF_SHDN_CTRL && !src_act)
    |=> (s_q.ctrl.event_flag == $past(hwdata[cws_pkg::BIT_EVENT])))
    else $error("software write to event flag lost");
  a_no_restart: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && !s_q.ctrl.auto_restart_enable && !wr_chk)
    |=> s_q.ctrl.event_flag)
    else $error("flag cleared without auto restart");
  a_restart_stat: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.ctrl.auto_restart_enable && !src_act && !wr_chk)
    |=> s_q.int_stat[cws_pkg::INT_RESTART])
    else $error("auto restart not recorded in status");
  a_lc_high: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.logic_cell_shutdown_enable && logic_cell_output) |=> s_q.ctrl.event_flag)
    else $error("high logic cell output did not shut down");
  a_fault_ignored: assert property (@(posedge clk) disable iff (reset)
    (!s_q.ctrl.fault_pin_shutdown_enable && !logic_cell_output) |-> !src_act)
    else $error("disabled fault pin caused shutdown");
  a_fault_sync: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> (s_q.flt_sync[1] == $past(s_q.flt_sync[0])))
    else $error("fault synchroniser skipped a stage");
  a_rd_ctrl_zero: assert property (@(posedge clk) disable iff (reset)
    (rd_chk && haddr[11:0] == cws_pkg::OFF_SHDN_CTRL)
    |=> ((hrdata & {24'hff_ffff, ~cws_pkg::CTRL_MASK}) == 32'h0000_0000))
    else $error("unimplemented control bits read nonzero");
  a_rd_dbr: assert property (@(posedge clk) disable iff (reset)
    (rd_chk && haddr[11:0] == cws_pkg::OFF_DBR)
    |=> (hrdata == {26'h000_0000, $past(s_q.rising_deadband_field)}))
    else $error("dead band register read wrong");
  a_dbr_write: assert property (@(posedge clk) disable iff (reset)
    (wr_chk && s_q.ph_addr == cws_pkg::OFF_DBR)
    |=> (s_q.rising_deadband_field == $past(hwdata[5:0])))
    else $error("dead band write lost");
  a_db_no_early: assert property (@(posedge clk) disable iff (reset)
    (wave_in && !s_q.a_drive && s_q.rising_deadband_field != 6'h00 && !db_tick)
    |=> !s_q.a_drive)
    else $error("rising edge passed without a dead band count");
  a_db_last_tick: assert property (@(posedge clk) disable iff (reset)
    (wave_in && !s_q.a_drive && db_tick && s_q.db_cnt <= 6'h01) |=> s_q.a_drive)
    else $error("rising edge held past its dead band");
  a_fall_now: assert property (@(posedge clk) disable iff (reset)
    !wave_in |=> !s_q.a_drive)
    else $error("output a did not fall at once");
  a_b_inverse: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> (s_q.b_drive == !$past(wave_in)))
    else $error("output b does not follow the inverse wave");
  a_lvl_low_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_a_shutdown_level == cws_pkg::LVL_LOW)
    |-> (!wave_out_a.level && !wave_out_a.oe))
    else $error("forced low level not driven on a");
  a_lvl_high_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_a_shutdown_level == cws_pkg::LVL_HIGH)
    |-> (wave_out_a.level && !wave_out_a.oe))
    else $error("forced high level not driven on a");
  a_lvl_tri_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_a_shutdown_level == cws_pkg::LVL_TRISTATE)
    |-> wave_out_a.oe)
    else $error("output a not released in shutdown");
  a_lvl_idle_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_a_shutdown_level == cws_pkg::LVL_INACTIVE)
    |-> (!wave_out_a.oe && wave_out_a.level == s_q.out_a_polarity))
    else $error("output a not inactive in shutdown");
  a_lvl_low_b: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_b_shutdown_level == cws_pkg::LVL_LOW)
    |-> (!wave_out_b.level && !wave_out_b.oe))
    else $error("forced low level not driven on b");
  a_lvl_tri_b: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_b_shutdown_level == cws_pkg::LVL_TRISTATE)
    |-> wave_out_b.oe)
    else $error("output b not released in shutdown");
  a_lvl_idle_b: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl.event_flag && s_q.out_b_shutdown_level == cws_pkg::LVL_INACTIVE)
    |-> (!wave_out_b.oe && wave_out_b.level == s_q.out_b_polarity))
    else $error("output b not inactive in shutdown");
  a_irq_masked: assert property (@(posedge clk) disable iff (reset)
    (s_q.int_en == 2'h0) |-> !irq)
    else $error("interrupt raised while masked");
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !rd_chk |=> (hrdata == 32'h0000_0000))
    else $error("read data stood past its data phase");
  a_bus_okay: assert property (@(posedge clk) disable iff (reset)
    (hreadyout && !hresp))
    else $error("bus response not ready and okay");

  c_shutdown: cover property (@(posedge clk) disable iff (reset) $rose(s_q.ctrl.event_flag));
  c_restart:  cover property (@(posedge clk) disable iff (reset) $fell(s_q.ctrl.event_flag));
  c_db_done:  cover property (@(posedge clk) disable iff (reset) $rose(s_q.a_drive));
  c_irq:      cover property (@(posedge clk) disable iff (reset) $rose(irq));
  c_new_src:  cover property (@(posedge clk) disable iff (reset) src_act && !s_q.src_prev);
endmodule // cws_shutdown

//--- tb/cws_drv_model.sv
// cws_drv_model: driver stage on the two wave pins and the fault source
// assumes pins are looked at on clk; fault line has a pull-up
`timescale 1ns/10ps
module cws_drv_model (
  input  wire logic              clk,
  input  wire cws_pkg::cws_pin_t wave_out_a,
  input  wire cws_pkg::cws_pin_t wave_out_b,
  input  wire logic              fault_assert,
  output logic                   fault_input_pin,
  output logic                   pin_a,
  output logic                   pin_b
);
  logic last_a_q = 1'b0;
  logic last_b_q = 1'b0;
  always_ff @(posedge clk) begin
    last_a_q <= pin_a;
    last_b_q <= pin_b;
  end
  // a floating pin toggles so a stale level is never mistaken for a drive
  assign pin_a = wave_out_a.oe ? ~last_a_q : wave_out_a.level;
  assign pin_b = wave_out_b.oe ? ~last_b_q : wave_out_b.level;
  // active low, the pull-up wins when no fault is asserted
  assign fault_input_pin = ~fault_assert;
endmodule // cws_drv_model

//--- tb/testbench.sv
// testbench: register, shutdown, interrupt and dead-band checks
// assumes cws_shutdown as a zero wait state ahb-lite slave
`timescale 1ns/10ps
module testbench;
  localparam logic [11:0] CTL = cws_pkg::OFF_SHDN_CTRL;
  localparam logic [11:0] STA = cws_pkg::OFF_INT_STAT;
  logic              clk = 0, reset = 1, db_tick = 0, wave_in = 0, lc = 0, flt = 0;
  logic              hsel = 0, hwrite = 0, hreadyout, hresp, irq, fpin, pin_a, pin_b;
  logic [31:0]       haddr = 0, hwdata = 0, hrdata, seed = 32'h3c3b, r;
  logic [1:0]        htrans = 0;
  logic [7:0]        e, n;
  cws_pkg::cws_pin_t wa, wb;
  int                err_count = 0, samples_checked = 0, cnt, cyc;
  logic [7:0]        tc [6] = '{8'h16, 8'h39, 8'h5f, 8'h05, 8'h0a, 8'h7b};

  initial forever #4 clk = ~clk;
  always @(posedge clk) db_tick <= ~db_tick;

  cws_shutdown cws_shutdown_inst (.clk(clk), .reset(reset), .db_tick(db_tick),
    .wave_in(wave_in), .logic_cell_output(lc), .fault_input_pin(fpin), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .wave_out_a(wa), .wave_out_b(wb), .irq(irq));
  cws_drv_model cws_drv_model_inst (.clk(clk), .wave_out_a(wa), .wave_out_b(wb),
    .fault_assert(flt), .fault_input_pin(fpin), .pin_a(pin_a), .pin_b(pin_b));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string s, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, exp, got);
    end
  endtask

  // called just after a rising edge; the bus never stalls but we still wait
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= cws_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string s);
    xfer(a, 1'b0, 32'h0);
    chk(s, exp, r);
    chk("hresp", 32'h0, hresp);
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish;
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(CTL, 32'h0, "ctrl reset");
    rd(12'h01c, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      xfer(CTL, 1'b1, seed & 32'h7c);
      rd(CTL, seed & 32'h40, "ctrl bits");
      xfer(cws_pkg::OFF_DBR, 1'b1, seed);
      rd(cws_pkg::OFF_DBR, seed & 32'h3f, "dbr");
    end
    xfer(CTL, 1'b1, 32'h80);
    rd(CTL, 32'h80, "flag written");
    xfer(CTL, 1'b1, 32'h0);
    $display("test registers done");
    xfer(cws_pkg::OFF_WAVE_CTRL, 1'b1, 32'h3);
    xfer(cws_pkg::OFF_INT_EN, 1'b1, 32'h1);
    wave_in <= 1'b1;
    repeat (140) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      e = tc[i];
      xfer(cws_pkg::OFF_LEVELS, 1'b1, {28'h0, ~e[6:5], e[6:5]});
      xfer(CTL, 1'b1, e[1:0]);
      lc <= e[2];
      flt <= e[3];
      repeat (6) @(posedge clk);
      rd(CTL, {e[4], 5'h0, e[1:0]}, "flag set");
      chk("irq", e[4], irq);
      chk("out a oe", e[4] && e[6:5] == 2'h1, wa.oe);
      if (!wa.oe) chk("out a level", e[4] ? e[6:5] == 2'h3 : 1'b1, wa.level);
      chk("out b oe", e[4] && e[6:5] == 2'h2, wb.oe);
      if (!wb.oe) chk("out b level", e[4] && e[6:5] == 2'h0, wb.level);
      lc <= 1'b0;
      flt <= 1'b0;
      repeat (4) @(posedge clk);
      rd(CTL, {e[4], 5'h0, e[1:0]}, "flag sticky");
      xfer(CTL, 1'b1, 32'h0);
      xfer(cws_pkg::OFF_INT_CLR, 1'b1, 32'h3);
      rd(STA, 32'h0, "stat clear");
      chk("irq clear", 1'b0, irq);
    end
    $display("test shutdown done");
    xfer(cws_pkg::OFF_INT_EN, 1'b1, 32'h0);
    xfer(CTL, 1'b1, 32'h42);
    lc <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CTL, 32'hc2, "restart set");
    chk("irq masked", 1'b0, irq);
    rd(STA, 32'h1, "stat entered");
    lc <= 1'b0;
    repeat (3) @(posedge clk);
    rd(CTL, 32'h42, "restart clear");
    rd(STA, 32'h3, "stat restart");
    xfer(cws_pkg::OFF_INT_EN, 1'b1, 32'h3);
    repeat (140) @(posedge clk);
    chk("irq on", 1'b1, irq);
    chk("out a back", 2'b01, wa);
    xfer(cws_pkg::OFF_INT_CLR, 1'b1, 32'h3);
    @(posedge clk);
    chk("irq off", 1'b0, irq);
    $display("test restart done");
    xfer(CTL, 1'b1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      n = i == 0 ? 8'h0 : i == 1 ? 8'h1 : i == 2 ? 8'h3f : {2'h0, seed[5:0]};
      xfer(cws_pkg::OFF_DBR, 1'b1, n);
      wave_in <= 1'b0;
      repeat (4) @(posedge clk);
      wave_in <= 1'b1;
      cnt = 0;
      cyc = 0;
      repeat (300) begin
        @(posedge clk);
        if (pin_a === 1'b1) break;
        cyc++;
        cnt += db_tick;
      end
      chk("dead band ticks", n, (n == 0) ? cyc - 1 : cnt);
      chk("pin b low", 1'b0, pin_b);
    end
    $display("test dead band done");
    tally_and_finish;
  end
endmodule // testbench
